// file: rtl/tss_pkg.sv
// package: register map, field layout, modes and timing for the trunk start supervision block
package tss_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] PULSE_DIAL_END_OFS = 8'h10;
    localparam logic [7:0] TONE_DIAL_END_OFS = 8'h14;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_STOPGO_POL = 2;
    localparam int CTRL_PSEUDO_EN = 3;
    localparam int CTRL_ADDR_TONE = 4;
    localparam int CTRL_ANSWER = 5;
    localparam int CTRL_SEIZE = 6;
    localparam int CTRL_TANDEM = 7;
    localparam int CTRL_GROUND_START = 8;
    localparam int CTRL_WIDTH = 9;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    // ------------------------------------------------------------
    // incoming_start_setting encodings
    // ------------------------------------------------------------
    localparam logic [1:0] IMMEDIATE_START_MODE = 2'h0;
    localparam logic [1:0] DELAY_DIAL_MODE = 2'h1;
    localparam logic [1:0] WINK_START_MODE = 2'h2;
    // ------------------------------------------------------------
    // status and interrupt bits
    // ------------------------------------------------------------
    localparam int ST_SEIZED = 0;
    localparam int ST_REVERSED = 1;
    localparam int ST_STOP = 2;
    localparam int ST_OUTPULSE = 3;
    localparam int ST_FAR_ANSWER = 4;
    localparam int ST_PSEUDO = 5;
    localparam int ST_LOOP_CLOSED = 6;
    localparam int EV_SEIZE = 0;
    localparam int EV_RELEASE = 1;
    localparam int EV_FAR_ANSWER = 2;
    localparam int EV_DIAL_END = 3;
    localparam int EV_FAULT = 4;
    localparam int EV_WIDTH = 5;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam logic [15:0] PULSE_DIAL_END_RESET = 16'h1F40;
    localparam logic [15:0] TONE_DIAL_END_RESET = 16'h0FA0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam logic [15:0] DELAY_DIAL_STOP_MS = 16'd384;
    localparam logic [15:0] WINK_PRE_MS = 16'd384;
    localparam logic [15:0] WINK_STOP_MS = 16'd256;
    localparam logic [15:0] TANDEM_LOOP_MS = 16'd1000;
    localparam logic [15:0] GO_TIMEOUT_MS = 16'd4000;
endpackage

// file: rtl/tss_trunk_start.sv
// trunk start supervision: seizure, polarity answer, stop/go and outpulse gating
`timescale 1ns/1ps
module tss_trunk_start
    import tss_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line sense
    input wire logic loop_current,
    input wire logic far_reversal,
    input wire logic far_stop,
    input wire logic ground_detect,
    input wire logic digit_event,
    // line drive
    output logic reverse_polarity,
    output logic near_offhook,
    output logic loop_close,
    output logic outpulse_enable,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle, st_in_pre, st_in_stop, st_in_digits, st_in_answered, st_in_cleared,
        st_out_wait, st_out_active, st_out_fail
    } tss_state_t;

    tss_state_t state;
    tss_state_t next_state;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [EV_WIDTH-1:0] irq_stat;
    logic [EV_WIDTH-1:0] irq_mask;
    logic [15:0] pulse_end_of_dial_time;
    logic [15:0] tone_end_of_dial_time;
    logic [15:0] ms_div;
    logic [15:0] ms_elapsed;
    logic ms_tick;
    logic restart;
    logic saw_far_stop;
    logic far_rev_q;
    logic pseudo;
    logic [EV_WIDTH-1:0] events;
    logic [1:0] incoming_start_setting;
    logic dial_end_hit;
    logic apb_wr;
    logic apb_setup;

    assign incoming_start_setting = ctrl[CTRL_MODE_LSB+:2];

    function automatic logic hit(input logic tick, input logic [15:0] el,
                                 input logic [15:0] lim);
        return tick && (lim != 16'h0000) && (el == lim - 16'h0001);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == CTRL_OFS || a == STATUS_OFS || a == IRQ_STAT_OFS ||
               a == IRQ_MASK_OFS || a == PULSE_DIAL_END_OFS || a == TONE_DIAL_END_OFS;
    endfunction

    // ------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------
    // restart keeps each interval exact from its starting event
    assign restart = (next_state != state) || (state == st_in_digits && digit_event);
    assign ms_tick = (ms_div == 16'(MS_TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_div <= 16'h0000;
        else if (restart || ms_tick)
            ms_div <= 16'h0000;
        else
            ms_div <= ms_div + 16'h0001;
    end

    // saturates so an expired interval cannot fire again after wrap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_elapsed <= 16'h0000;
        else if (restart)
            ms_elapsed <= 16'h0000;
        else if (ms_tick && ms_elapsed != 16'hFFFF)
            ms_elapsed <= ms_elapsed + 16'h0001;
    end

    // ------------------------------------------------------------
    // call sequencer
    // ------------------------------------------------------------
    assign dial_end_hit = hit(ms_tick, ms_elapsed, ctrl[CTRL_ADDR_TONE] ?
                         tone_end_of_dial_time : pulse_end_of_dial_time);

    always_comb
    begin
        next_state = state;
        case (state)
            st_idle:
                if (ctrl[CTRL_SEIZE])
                    next_state = st_out_wait;
                else if (loop_current)
                    case (incoming_start_setting)
                        DELAY_DIAL_MODE: next_state = st_in_stop;
                        WINK_START_MODE: next_state = st_in_pre;
                        default: next_state = st_in_digits;
                    endcase
            st_in_pre:
                if (!loop_current)
                    next_state = st_idle;
                else if (hit(ms_tick, ms_elapsed, WINK_PRE_MS))
                    next_state = st_in_stop;
            st_in_stop:
                if (!loop_current)
                    next_state = st_idle;
                else if (hit(ms_tick, ms_elapsed, incoming_start_setting == WINK_START_MODE ?
                              WINK_STOP_MS : DELAY_DIAL_STOP_MS))
                    next_state = st_in_digits;
            st_in_digits:
                if (!loop_current)
                    next_state = st_idle;
                else if (ctrl[CTRL_ANSWER] || (dial_end_hit && ctrl[CTRL_PSEUDO_EN]))
                    next_state = st_in_answered;
            st_in_answered:
                if (!loop_current)
                    next_state = st_idle;
                else if (!ctrl[CTRL_ANSWER] && !pseudo)
                    next_state = st_in_cleared;
            st_in_cleared:
                if (!loop_current)
                    next_state = st_idle;
            st_out_wait:
                if (!ctrl[CTRL_SEIZE])
                    next_state = st_idle;
                else if (ctrl[CTRL_TANDEM])
                begin
                    if (ctrl[CTRL_GROUND_START] ? ground_detect :
                        hit(ms_tick, ms_elapsed, TANDEM_LOOP_MS))
                        next_state = st_out_active;
                end
                else if (incoming_start_setting == IMMEDIATE_START_MODE)
                    next_state = st_out_active;
                else if (saw_far_stop && !far_stop)
                    next_state = st_out_active;
                else if (hit(ms_tick, ms_elapsed, GO_TIMEOUT_MS))
                    next_state = st_out_fail;
            st_out_active:
                if (!ctrl[CTRL_SEIZE])
                    next_state = st_idle;
            st_out_fail:
                if (!ctrl[CTRL_SEIZE])
                    next_state = st_idle;
            default:
                next_state = st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= st_idle;
        else
            state <= next_state;
    end

    // pseudo answer holds until the far end releases; software cannot undo it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pseudo <= 1'b0;
        else if (state == st_in_digits && next_state == st_in_answered && !ctrl[CTRL_ANSWER])
            pseudo <= 1'b1;
        else if (next_state == st_idle)
            pseudo <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            saw_far_stop <= 1'b0;
        else if (state != st_out_wait)
            saw_far_stop <= 1'b0;
        else if (far_stop)
            saw_far_stop <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            far_rev_q <= 1'b0;
        else
            far_rev_q <= far_reversal;
    end

    // ------------------------------------------------------------
    // line outputs
    // ------------------------------------------------------------
    // stop goes out as reversal or off-hook; reversal also carries answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reverse_polarity <= 1'b0;
            near_offhook <= 1'b0;
            loop_close <= 1'b0;
            outpulse_enable <= 1'b0;
        end
        else
        begin
            reverse_polarity <= (next_state == st_in_answered) ||
                                (next_state == st_in_stop && ctrl[CTRL_STOPGO_POL]);
            near_offhook <= next_state == st_in_stop && !ctrl[CTRL_STOPGO_POL];
            loop_close <= next_state == st_out_wait || next_state == st_out_active;
            outpulse_enable <= next_state == st_out_active;
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        events = '0;
        events[EV_SEIZE] = state == st_idle && next_state != st_idle && !ctrl[CTRL_SEIZE];
        events[EV_RELEASE] = state != st_idle && next_state == st_idle;
        events[EV_FAR_ANSWER] = state == st_out_active && far_reversal && !far_rev_q;
        events[EV_DIAL_END] = state == st_in_digits && dial_end_hit;
        events[EV_FAULT] = (state == st_out_wait && next_state == st_out_fail) ||
                           ((state == st_in_pre || state == st_in_stop) && !loop_current);
    end

    assign apb_wr = psel && penable && pwrite;
    assign apb_setup = psel && !penable;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else if (apb_wr && paddr == IRQ_STAT_OFS)
            irq_stat <= (irq_stat & ~pwdata[EV_WIDTH-1:0]) | events;
        else
            irq_stat <= irq_stat | events;
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
            pulse_end_of_dial_time <= PULSE_DIAL_END_RESET;
            tone_end_of_dial_time <= TONE_DIAL_END_RESET;
        end
        else if (apb_wr)
            case (paddr)
                CTRL_OFS: ctrl <= pwdata[CTRL_WIDTH-1:0];
                IRQ_MASK_OFS: irq_mask <= pwdata[EV_WIDTH-1:0];
                PULSE_DIAL_END_OFS: pulse_end_of_dial_time <= pwdata[15:0];
                TONE_DIAL_END_OFS: tone_end_of_dial_time <= pwdata[15:0];
                default: ;
            endcase
    end

    // read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_setup)
        begin
            prdata <= 32'h00000000;
            case (paddr)
                CTRL_OFS: prdata[CTRL_WIDTH-1:0] <= ctrl;
                STATUS_OFS:
                begin
                    prdata[ST_SEIZED] <= state inside {st_in_pre, st_in_stop, st_in_digits,
                                                      st_in_answered, st_in_cleared};
                    prdata[ST_REVERSED] <= reverse_polarity;
                    prdata[ST_STOP] <= state == st_in_stop;
                    prdata[ST_OUTPULSE] <= outpulse_enable;
                    prdata[ST_FAR_ANSWER] <= state == st_out_active && far_reversal;
                    prdata[ST_PSEUDO] <= pseudo;
                    prdata[ST_LOOP_CLOSED] <= loop_close;
                end
                IRQ_STAT_OFS: prdata[EV_WIDTH-1:0] <= irq_stat;
                IRQ_MASK_OFS: prdata[EV_WIDTH-1:0] <= irq_mask;
                PULSE_DIAL_END_OFS: prdata[15:0] <= pulse_end_of_dial_time;
                TONE_DIAL_END_OFS: prdata[15:0] <= tone_end_of_dial_time;
                default: ;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_SEIZE_DETECT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_idle && loop_current && !ctrl[CTRL_SEIZE]) |=> state != st_idle)
        else $error("incoming loop not taken as seizure");
    AST_MODE_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_idle && loop_current && !ctrl[CTRL_SEIZE] &&
         incoming_start_setting == WINK_START_MODE) |=> state == st_in_pre ##1 !near_offhook)
        else $error("wink mode did not wait before stop");
    AST_DD_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_idle && loop_current && !ctrl[CTRL_SEIZE] && !ctrl[CTRL_STOPGO_POL] &&
         incoming_start_setting == DELAY_DIAL_MODE) |=> near_offhook)
        else $error("delay dial stop not raised at seizure");
    AST_STOP_END: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_in_stop && loop_current && hit(ms_tick, ms_elapsed,
         incoming_start_setting == WINK_START_MODE ? WINK_STOP_MS : DELAY_DIAL_STOP_MS))
        |=> state == st_in_digits && !near_offhook)
        else $error("go signal not returned at end of stop");
    AST_STOP_AFTER_SEIZE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == st_in_stop) |-> $past(loop_current))
        else $error("stop signal without a seizure");
    AST_ANSWER_REVERSE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_in_digits && loop_current && ctrl[CTRL_ANSWER]) |=> reverse_polarity)
        else $error("answer did not reverse polarity");
    AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_in_answered && !loop_current) |=> state == st_idle && !reverse_polarity)
        else $error("far release did not restore polarity");
    AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_out_wait && !saw_far_stop && !ctrl[CTRL_TANDEM] &&
         incoming_start_setting != IMMEDIATE_START_MODE) |=> !outpulse_enable)
        else $error("outpulse before far go signal");
    AST_TANDEM_GROUND: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_out_wait && ctrl[CTRL_SEIZE] && ctrl[CTRL_TANDEM] &&
         ctrl[CTRL_GROUND_START] && ground_detect) |=> outpulse_enable)
        else $error("tandem outpulse not started on ground detect");
    AST_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_in_stop && !loop_current) |=> irq_stat[EV_FAULT])
        else $error("broken stop/go exchange not flagged");
    AST_PSEUDO: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_in_digits && loop_current && dial_end_hit && ctrl[CTRL_PSEUDO_EN] &&
         !ctrl[CTRL_ANSWER]) |=> pseudo && reverse_polarity)
        else $error("no pseudo answer at end of dial");
    AST_TICK_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (state != next_state) |=> ms_elapsed == 16'h0000 && ms_div == 16'h0000)
        else $error("interval counters not cleared on state change");
    AST_FAR_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        (state == st_out_active && $rose(far_reversal)) |=> irq_stat[EV_FAR_ANSWER])
        else $error("far answer reversal not reported");
endmodule

// file: bench/tss_far_end.sv
// far-end pbx model: seizes, answers, winks on outgoing seizure, sends one digit
`timescale 1ns/1ps
module tss_far_end #(
    parameter int MS = 2
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic call,
    input wire logic answer,
    input wire logic expect_stop,
    // near end line state
    input wire logic loop_close,
    input wire logic near_stop,
    // line toward near end
    output logic loop_current,
    output logic far_reversal,
    output logic far_stop,
    output logic ground_detect,
    output logic digit_event
);
    int quiet;
    int held;
    logic seen;
    // ------------------------------------------------------------
    // line levels
    // ------------------------------------------------------------
    assign loop_current = call;
    assign far_reversal = answer & loop_close;
    assign ground_detect = loop_close;
    // stop 10 ms after near seizure, go 140 ms later
    assign far_stop = loop_close && held >= 10 * MS && held < 150 * MS;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quiet <= 0;
            held <= 0;
            seen <= 1'b0;
            digit_event <= 1'b0;
        end
        else
        begin
            held <= loop_close ? held + 1 : 0;
            quiet <= (call && !near_stop) ? quiet + 1 : 0;
            seen <= call && (seen || near_stop);
            // a wink far end must not dial before it has seen stop
            digit_event <= call && (seen || !expect_stop) && quiet == 65 * MS;
        end
    end
endmodule

// file: bench/tb_tss_trunk_start.sv
// testbench: trunk start block against a far-end pbx model
`timescale 1ns/1ps
module tb_tss_trunk_start;
    import tss_pkg::*;
    localparam int MS = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, pol, saw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctl;
    logic loop_current, far_reversal, far_stop, ground_detect, digit_event;
    logic reverse_polarity, near_offhook, loop_close, outpulse_enable;
    logic call, answer, expect_stop;
    int bad_count = 0;
    int num_checks = 0;
    int seed, cnt, first, t, exp_irq;
    logic [1:0] md[3] = '{DELAY_DIAL_MODE, WINK_START_MODE, IMMEDIATE_START_MODE};
    int lead[3] = '{0, 384 * MS, -1};
    int span[3] = '{384 * MS, 256 * MS, 0};
    tss_trunk_start #(.MS_TICK_CYCLES(MS)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .loop_current, .far_reversal, .far_stop,
        .ground_detect, .digit_event, .reverse_polarity, .near_offhook, .loop_close,
        .outpulse_enable, .irq);
    tss_far_end #(.MS(MS)) far (.pclk, .presetn, .call, .answer, .expect_stop, .loop_close,
        .near_stop(near_offhook | (pol & reverse_polarity)), .loop_current, .far_reversal,
        .far_stop, .ground_detect, .digit_event);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // watchdog: whole run is about 7100 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        stop_test();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        seed = 43;
        {presetn, psel, penable, pwrite, paddr, pwdata, call, answer, expect_stop, pol} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, PULSE_DIAL_END_OFS, 32'h0);
        chk(rd, 32'h1F40);
        apb(1'b0, TONE_DIAL_END_OFS, 32'h0);
        chk(rd, 32'h0FA0);
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, IRQ_MASK_OFS, $random(seed));
        ctl = pwdata;
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        chk(rd, ctl & 32'h1F);
        apb(1'b1, IRQ_MASK_OFS, 32'h1F);
        // incoming seizure in each start mode; wink uses polarity for stop
        for (int i = 0; i < 3; i++)
        begin
            pol <= (i == 1);
            ctl = {29'h0, i == 1, md[i]};
            apb(1'b1, CTRL_OFS, ctl);
            expect_stop <= (i < 2);
            call <= 1'b1;
            first = -1;
            cnt = 0;
            for (t = 0; t < 700 * MS; t++)
            begin
                @(posedge pclk);
                if ((pol ? reverse_polarity : near_offhook) === 1'b1)
                begin
                    first = (first < 0) ? t : first;
                    cnt++;
                end
            end
            chk(first >= lead[i] && first <= lead[i] + 3, 1);
            chk(cnt, span[i]);
            apb(1'b1, CTRL_OFS, ctl | 32'h20);
            repeat (2) @(posedge pclk);
            chk(reverse_polarity, 1'b1);
            call <= 1'b0;
            repeat (3) @(posedge pclk);
            chk({reverse_polarity, irq}, 2'b01);
            exp_irq = (1 << EV_SEIZE) | (1 << EV_RELEASE);
            apb(1'b0, IRQ_STAT_OFS, 32'h0);
            chk(rd, exp_irq);
            apb(1'b1, IRQ_STAT_OFS, rd);
            apb(1'b1, CTRL_OFS, 32'h0);
            chk(irq, 1'b0);
        end
        // loop dropped in the middle of the stop signal
        apb(1'b1, CTRL_OFS, {30'h0, DELAY_DIAL_MODE});
        call <= 1'b1;
        repeat (40) @(posedge pclk);
        call <= 1'b0;
        repeat (3) @(posedge pclk);
        exp_irq = exp_irq | (1 << EV_FAULT);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, exp_irq);
        apb(1'b1, IRQ_STAT_OFS, rd);
        // tone end-of-dial picked over a long pulse setting
        apb(1'b1, PULSE_DIAL_END_OFS, 32'd1000);
        apb(1'b1, TONE_DIAL_END_OFS, 32'd5);
        apb(1'b1, CTRL_OFS, 32'h18);
        call <= 1'b1;
        repeat (40 * MS) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[ST_PSEUDO], 1'b1);
        call <= 1'b0;
        repeat (3) @(posedge pclk);
        exp_irq = (1 << EV_SEIZE) | (1 << EV_RELEASE) | (1 << EV_DIAL_END);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, exp_irq);
        apb(1'b1, IRQ_STAT_OFS, rd);
        // outgoing wink call: no outpulse before far go
        apb(1'b1, CTRL_OFS, 32'h40 | WINK_START_MODE);
        saw = 1'b0;
        repeat (200 * MS)
        begin
            @(posedge pclk);
            saw = saw | far_stop;
            if (outpulse_enable === 1'b1 && !(saw && !far_stop))
                chk(1'b0, 1'b1);
        end
        chk({loop_close, outpulse_enable}, 2'b11);
        answer <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd[EV_FAR_ANSWER], 1'b1);
        apb(1'b1, CTRL_OFS, 32'h0);
        // loop_close is registered from the next state, one edge after the write lands
        @(posedge pclk);
        chk(loop_close, 1'b0);
        // tandem toward the office: ground start goes on ground detect, loop start after 1 s
        apb(1'b1, CTRL_OFS, 32'h1C0);
        repeat (2) @(posedge pclk);
        chk(outpulse_enable, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'hC0);
        first = -1;
        for (t = 0; t < 1100 * MS; t++)
        begin
            @(posedge pclk);
            if (outpulse_enable === 1'b1 && first < 0)
                first = t;
        end
        chk(first >= 1000 * MS - 1 && first <= 1000 * MS + 1, 1);
        apb(1'b1, CTRL_OFS, 32'h0);
        stop_test();
    end
endmodule
